//--- design/rf_cfg_pkg.sv
/*
 * package for the rf configuration command handler: command codes,
 * item codes, payload lengths, register offsets and reset defaults.
 * assumes one 125 MHz clock and a classic wishbone register bus.
 */
package rf_cfg_pkg;
	// command codes in the command register
	localparam logic [7:0] CMD_RF_SETUP = 8'h32;
	localparam logic [7:0] CMD_REG_TEST = 8'h58;
	// configuration item codes
	localparam logic [7:0] ITEM_TIMING = 8'h02;
	localparam logic [7:0] ITEM_RAW_RETRY = 8'h04;
	localparam logic [7:0] ITEM_RETRIES = 8'h05;
	localparam logic [7:0] ITEM_A106 = 8'h0A;
	localparam logic [7:0] ITEM_F212 = 8'h0B;
	localparam logic [7:0] ITEM_TYPE_B = 8'h0C;
	localparam logic [7:0] ITEM_CARD_HI = 8'h0D;
	// payload lengths per item
	localparam logic [3:0] LEN_TIMING = 4'h3;
	localparam logic [3:0] LEN_RAW_RETRY = 4'h1;
	localparam logic [3:0] LEN_RETRIES = 4'h3;
	localparam logic [3:0] LEN_A106 = 4'hB;
	localparam logic [3:0] LEN_F212 = 4'h8;
	localparam logic [3:0] LEN_TYPE_B = 4'h3;
	localparam logic [3:0] LEN_CARD_HI = 4'h9;
	localparam logic [7:0] TIMING_MAX = 8'h10;
	// retry counts
	localparam logic [7:0] RETRY_FOREVER = 8'hFF;
	localparam logic [7:0] RST_RAW_RETRY = 8'h00;
	localparam logic [7:0] RST_ATTR_RETRY = 8'hFF;
	localparam logic [7:0] RST_PSEL_RETRY = 8'h01;
	localparam logic [7:0] RST_PACT_RETRY = 8'hFF;
	localparam logic [7:0] PASSIVE_ATTR_RETRY = 8'h02;
	// status codes
	localparam logic [1:0] ST_IDLE = 2'h0;
	localparam logic [1:0] ST_OK = 2'h1;
	localparam logic [1:0] ST_SYNTAX = 2'h2;
	localparam logic [1:0] ST_TESTING = 2'h3;
	// register word indices (byte address = 4 * index)
	localparam logic [5:0] REG_PAYLOAD = 6'h00;
	localparam logic [5:0] REG_CMD = 6'h01;
	localparam logic [5:0] REG_STATUS = 6'h02;
	localparam logic [5:0] REG_RETRY = 6'h03;
	localparam logic [5:0] REG_PATH = 6'h04;
	localparam logic [5:0] REG_TEST = 6'h05;
	localparam logic [5:0] REG_A106_BASE = 6'h08;
	localparam logic [5:0] REG_F212_BASE = 6'h14;
	localparam logic [5:0] REG_TB_BASE = 6'h1C;
	localparam logic [5:0] REG_CH_BASE = 6'h20;
	localparam logic [5:0] REG_TIME_BASE = 6'h2C;
	localparam logic [31:0] ACK_DATA_NONE = 32'h0000_0000;
	// analog reset tables, byte 1 in the low byte
	localparam logic [87:0] RST_A106 =
		88'h87_62_26_6F_61_85_4D_11_3F_F4_59;
	localparam logic [63:0] RST_F212 = 64'h6F_61_85_41_11_3F_FF_69;
	localparam logic [23:0] RST_TYPE_B = 24'h85_17_FF;
	localparam logic [71:0] RST_CARD_HI =
		72'hDA_01_85_B2_08_85_8A_15_85;
	localparam logic [23:0] RST_TIMING = 24'h0A_0B_00;

	typedef struct packed {
		logic [2:0] rate;
		logic [1:0] framing;
		logic prbs_en;
	} test_mode_t;
endpackage

//--- design/rf_config_command_handler.sv
/*
 * rf configuration and regulation test command handler.
 * software pushes payload bytes, then writes a command code; the block
 * checks the item and length, stores the values and reports a status.
 * assumes a classic wishbone master and a synchronous reset.
 */
// Contract
// - item 0x04 stores raw-exchange retry count
// - count 0xFF retries raw exchange forever
// - raw-exchange retry count resets to 0x00
// - item 0x05 stores three retry counts
// - active attribute retry uses stored count
// - passive attribute retry fixed at two
// - parameter-select retry count default one
// - passive activation retry count default forever
// - item 0x0A loads eleven 106 type A settings
// - demodulator picks own-field on or off value
// - item 0x0B loads eight 212/424 settings
// - item 0x0C loads type B, rest from A
// - item 0x0D loads three card triplets
// - timing byte above 0x10 gives syntax error
// - bad item or length gives syntax error
// - test rate from mode bits 6..4
// - test framing from mode bits 1..0
// - test sets the prbs enable bit
// - test never ends, no response
// - any new command other than the test code stops the test
// - frame is item code then payload
`timescale 1ns/1ps
module rf_config_command_handler (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_srst,
	// wishbone slave
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	output logic o_wb_ack,
	output logic [31:0] o_wb_dat,
	// analog front end state
	input wire logic i_own_field_on,
	input wire logic i_passive_mode,
	output logic [7:0] o_demodulator_reg,
	output logic [7:0] o_attribute_retry_eff,
	output logic o_raw_retry_forever,
	// regulation test drive
	output rf_cfg_pkg::test_mode_t o_test_select_reg
);
	import rf_cfg_pkg::*;

	typedef enum logic [1:0] {
		S_IDLE = 2'b00,
		S_EXEC = 2'b01,
		S_TEST = 2'b11
	} state_t;

	////////////////////////////////////////////////////////////////////
	// storage
	state_t state_q, state_d;
	logic [7:0] buf_q [0:11];
	logic [3:0] cnt_q;
	logic [7:0] cmd_q;
	logic [1:0] status_q;
	logic [7:0] raw_retry_q, attr_retry_q, psel_retry_q, pact_retry_q;
	logic [87:0] a106_q;
	logic [63:0] f212_q;
	logic [23:0] tb_q;
	logic [71:0] ch_q;
	logic [23:0] time_q;
	test_mode_t test_q;
	logic ack_q;
	logic [31:0] rdat_q;

	function automatic logic [7:0] tbl_byte(input logic [87:0] t,
		input logic [3:0] i);
		tbl_byte = t[i*8 +: 8];
	endfunction

	////////////////////////////////////////////////////////////////////
	// bus decode
	wire req = i_wb_cyc & i_wb_stb & ~ack_q;
	wire [5:0] idx = i_wb_adr[7:2];
	wire wr_en = req & i_wb_we & i_wb_sel[0];
	wire push = wr_en & (idx == REG_PAYLOAD) & (state_q != S_EXEC);
	wire cmd_wr = wr_en & (idx == REG_CMD) & (state_q != S_EXEC);

	////////////////////////////////////////////////////////////////////
	// command check
	// byte 0 is item code
	wire [7:0] item = buf_q[0];
	wire [3:0] plen = cnt_q - 4'h1;
	wire timing_bad = (buf_q[1] > TIMING_MAX) | (buf_q[2] > TIMING_MAX)
		| (buf_q[3] > TIMING_MAX);
	logic item_ok;
	always_comb begin
		unique case (item)
			ITEM_TIMING: item_ok = (plen == LEN_TIMING) & ~timing_bad;
			ITEM_RAW_RETRY: item_ok = (plen == LEN_RAW_RETRY);
			ITEM_RETRIES: item_ok = (plen == LEN_RETRIES);
			ITEM_A106: item_ok = (plen == LEN_A106);
			ITEM_F212: item_ok = (plen == LEN_F212);
			ITEM_TYPE_B: item_ok = (plen == LEN_TYPE_B);
			ITEM_CARD_HI: item_ok = (plen == LEN_CARD_HI);
			default: item_ok = 1'b0;
		endcase
		if (cnt_q == 4'h0) begin
			item_ok = 1'b0;
		end
	end
	wire exec = (state_q == S_EXEC);
	wire store = exec & item_ok;

	// payload packed with byte 1 low
	logic [87:0] pay;
	always_comb begin
		pay = '0;
		for (int i = 0; i < 11; i++) begin
			pay[i*8 +: 8] = buf_q[i+1];
		end
	end

	////////////////////////////////////////////////////////////////////
	// state machine
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			S_IDLE: if (cmd_wr) begin
				state_d = (i_wb_dat[7:0] == CMD_REG_TEST) ? S_TEST
					: S_EXEC;
			end
			S_EXEC: state_d = S_IDLE;
			S_TEST: if (cmd_wr) begin
				state_d = (i_wb_dat[7:0] == CMD_REG_TEST) ? S_TEST
					: S_EXEC;
			end
			default: state_d = S_IDLE;
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			state_q <= S_IDLE;
			cnt_q <= 4'h0;
			cmd_q <= 8'h00;
		end else begin
			state_q <= state_d;
			if (cmd_wr) begin
				cmd_q <= i_wb_dat[7:0];
			end
			// buffer cleared after each command
			if (exec | (cmd_wr & (i_wb_dat[7:0] == CMD_REG_TEST))) begin
				cnt_q <= 4'h0;
			end else if (push & (cnt_q != 4'hC)) begin
				cnt_q <= cnt_q + 4'h1;
			end
		end
	end

	// overflow bytes dropped; length then mismatches, except item 0x0A whose eleven bytes still pass
	always_ff @(posedge i_clk) begin
		if (push & (cnt_q != 4'hC)) begin
			buf_q[cnt_q] <= i_wb_dat[7:0];
		end
	end

	////////////////////////////////////////////////////////////////////
	// stored settings
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			raw_retry_q <= RST_RAW_RETRY;
			attr_retry_q <= RST_ATTR_RETRY;
			psel_retry_q <= RST_PSEL_RETRY;
			pact_retry_q <= RST_PACT_RETRY;
			a106_q <= RST_A106;
			f212_q <= RST_F212;
			tb_q <= RST_TYPE_B;
			ch_q <= RST_CARD_HI;
			time_q <= RST_TIMING;
			status_q <= ST_IDLE;
		end else begin
			if (store & (cmd_q == CMD_RF_SETUP)) begin
				unique case (item)
					ITEM_TIMING: time_q <= pay[23:0];
					ITEM_RAW_RETRY: raw_retry_q <= pay[7:0];
					ITEM_RETRIES: begin
						attr_retry_q <= pay[7:0];
						psel_retry_q <= pay[15:8];
						pact_retry_q <= pay[23:16];
					end
					ITEM_A106: a106_q <= pay;
					ITEM_F212: f212_q <= pay[63:0];
					ITEM_TYPE_B: tb_q <= pay[23:0];
					ITEM_CARD_HI: ch_q <= pay[71:0];
					default: time_q <= time_q;
				endcase
			end
			if (cmd_wr & (i_wb_dat[7:0] == CMD_REG_TEST)) begin
				status_q <= ST_TESTING;
			end else if (exec) begin
				status_q <= (item_ok & (cmd_q == CMD_RF_SETUP)) ? ST_OK
					: ST_SYNTAX;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// regulation test and front end outputs
	// mode byte is the first pushed payload byte, zero if none
	wire [7:0] mode_byte = (cnt_q != 4'h0) ? buf_q[0] : 8'h00;
	wire [2:0] mode_rate = mode_byte[6:4];
	wire [1:0] mode_frame = mode_byte[1:0];
	wire [7:0] demod_d = i_own_field_on ? tbl_byte(a106_q, 4'h4)
		: tbl_byte(a106_q, 4'h6);
	wire [7:0] attr_eff_d = i_passive_mode ? PASSIVE_ATTR_RETRY
		: attr_retry_q;

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			test_q <= '0;
			o_demodulator_reg <= tbl_byte(RST_A106, 4'h6);
			o_attribute_retry_eff <= RST_ATTR_RETRY;
			o_raw_retry_forever <= 1'b0;
		end else begin
			if (cmd_wr & (i_wb_dat[7:0] == CMD_REG_TEST)) begin
				test_q.rate <= mode_rate;
				test_q.framing <= mode_frame;
				test_q.prbs_en <= 1'b1;
			end else if (cmd_wr) begin
				test_q.prbs_en <= 1'b0;
			end
			o_demodulator_reg <= demod_d;
			o_attribute_retry_eff <= attr_eff_d;
			o_raw_retry_forever <= (raw_retry_q == RETRY_FOREVER);
		end
	end
	assign o_test_select_reg = test_q;

	////////////////////////////////////////////////////////////////////
	// read mux; unmapped words read zero
	logic [31:0] rmux;
	always_comb begin
		rmux = ACK_DATA_NONE;
		if (idx == REG_CMD) begin
			rmux = {24'h0, cmd_q};
		end else if (idx == REG_STATUS) begin
			rmux = {24'h0, cnt_q, 2'b00, status_q};
		end else if (idx == REG_RETRY) begin
			rmux = {pact_retry_q, psel_retry_q, attr_retry_q,
				raw_retry_q};
		end else if (idx == REG_PATH) begin
			rmux = {16'h0, attr_eff_d, demod_d};
		end else if (idx == REG_TEST) begin
			rmux = {24'h0, 1'b0, test_q.rate, 1'b0, test_q.prbs_en,
				test_q.framing};
		end else if (idx >= REG_A106_BASE && idx < REG_A106_BASE + 6'd11)
			begin
			rmux = {24'h0, tbl_byte(a106_q, 4'(idx - REG_A106_BASE))};
		end else if (idx >= REG_F212_BASE && idx < REG_F212_BASE + 6'd8)
			begin
			rmux = {24'h0, tbl_byte({24'h0, f212_q},
				4'(idx - REG_F212_BASE))};
		end else if (idx >= REG_TB_BASE && idx < REG_TB_BASE + 6'd3) begin
			rmux = {24'h0, tbl_byte({64'h0, tb_q}, 4'(idx - REG_TB_BASE))};
		end else if (idx >= REG_CH_BASE && idx < REG_CH_BASE + 6'd9) begin
			rmux = {24'h0, tbl_byte({16'h0, ch_q}, 4'(idx - REG_CH_BASE))};
		end else if (idx >= REG_TIME_BASE && idx < REG_TIME_BASE + 6'd3)
			begin
			rmux = {24'h0, tbl_byte({64'h0, time_q},
				4'(idx - REG_TIME_BASE))};
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			ack_q <= 1'b0;
			rdat_q <= ACK_DATA_NONE;
		end else begin
			ack_q <= req;
			rdat_q <= (req & ~i_wb_we) ? rmux : ACK_DATA_NONE;
		end
	end
	assign o_wb_ack = ack_q;
	assign o_wb_dat = rdat_q;
endmodule

//--- verification/rf_cfg_asserts.sv
/*
 * checker for the rf configuration command handler ports.
 * assumes a classic wishbone master that idles one cycle between cycles.
 */
`timescale 1ns/1ps
module rf_cfg_asserts import rf_cfg_pkg::*; (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_srst,
	// wishbone
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	input wire logic o_wb_ack,
	input wire logic [31:0] o_wb_dat,
	// front end and test
	input wire logic i_own_field_on,
	input wire logic i_passive_mode,
	input wire logic [7:0] o_demodulator_reg,
	input wire logic [7:0] o_attribute_retry_eff,
	input wire logic o_raw_retry_forever,
	input wire test_mode_t o_test_select_reg
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_srst);
	wire take = i_wb_cyc && i_wb_stb && !o_wb_ack;
	wire cmd_wr = take && i_wb_we && i_wb_adr[7:2] == REG_CMD;
	wire go = cmd_wr && i_wb_dat[7:0] == CMD_REG_TEST;
	wire prbs = o_test_select_reg.prbs_en;
	////////////////////////////////////////////////////////////////
	ack_latency_a: assert property (take |=> o_wb_ack)
		else $error("ack missing after request");
	ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack)
		else $error("ack longer than one cycle");
	ack_cause_a: assert property (o_wb_ack |-> $past(take))
		else $error("ack without request");
	dat_idle_a: assert property (!o_wb_ack |-> o_wb_dat == 32'h0)
		else $error("read data outside ack");
	reset_vals_a: assert property ($past(i_srst) |->
		o_demodulator_reg == 8'h61 && !o_raw_retry_forever && !prbs)
		else $error("bad value after reset");
	passive_attr_a: assert property ($past(i_passive_mode) &&
		!$past(i_srst) |-> o_attribute_retry_eff == PASSIVE_ATTR_RETRY)
		else $error("passive attribute retry not two");
	test_start_a: assert property (go |-> ##[1:2] prbs)
		else $error("prbs not enabled by test");
	test_stop_a: assert property (cmd_wr && !go |-> ##[1:2] !prbs)
		else $error("test not ended by command");
	test_hold_a: assert property ($fell(prbs) && !$past(i_srst) |->
		$past(cmd_wr) || $past(cmd_wr, 2))
		else $error("test ended on its own");
	cover property (go);
	cover property (cmd_wr && !go);
	cover property ($past(i_passive_mode) && i_own_field_on);
endmodule
bind rf_config_command_handler rf_cfg_asserts chk_i (.*);

//--- verification/host_model.sv
/*
 * host controller model: classic wishbone master, one cycle at a time.
 * assumes callers enter xfer just after a rising clock edge.
 */
`timescale 1ns/1ps
module host_model (
	// clock
	input wire logic i_clk,
	// wishbone master
	input wire logic i_wb_ack,
	input wire logic [31:0] i_wb_dat,
	output logic o_wb_cyc = 1'b0,
	output logic o_wb_stb = 1'b0,
	output logic o_wb_we = 1'b0,
	output logic [7:0] o_wb_adr = 8'h00,
	output logic [3:0] o_wb_sel = 4'h0,
	output logic [31:0] o_wb_dat = 32'h0
);
	task automatic xfer(input logic w, input logic [5:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n = 0;
		o_wb_cyc <= 1'b1;
		o_wb_stb <= 1'b1;
		o_wb_we <= w;
		o_wb_adr <= {a, 2'b00};
		o_wb_sel <= 4'h1;
		o_wb_dat <= d;
		@(posedge i_clk);
		while (i_wb_ack !== 1'b1 && n < 50) begin
			@(posedge i_clk);
			n++;
		end
		q = i_wb_dat;
		// idle data lines change so stale values never match
		o_wb_cyc <= 1'b0;
		o_wb_stb <= 1'b0;
		o_wb_dat <= ~d;
		@(posedge i_clk);
	endtask
endmodule

//--- verification/tb.sv
/*
 * self-checking bench for the rf configuration command handler.
 * assumes one 125 MHz clock and the host model as bus master.
 */
`timescale 1ns/1ps
module tb;
	import rf_cfg_pkg::*;
	logic i_clk = 1'b0;
	logic i_srst = 1'b1;
	logic fld = 1'b0;
	logic pas = 1'b0;
	wire cyc, stb, we, ack;
	wire [7:0] adr, dem, att;
	wire [3:0] sel;
	wire [31:0] wd, rdat;
	wire forever_q;
	test_mode_t tst;
	int errors = 0;
	int n_tests = 0;
	int cyc_n = 0;
	logic [31:0] q;
	logic [7:0] bad [8] = '{8'h00, 8'h03, 8'h06, 8'h07, 8'h08, 8'h09,
		8'h0E, 8'hFF};
	host_model host (.i_clk(i_clk), .i_wb_ack(ack), .i_wb_dat(rdat),
		.o_wb_cyc(cyc), .o_wb_stb(stb), .o_wb_we(we), .o_wb_adr(adr),
		.o_wb_sel(sel), .o_wb_dat(wd));
	rf_config_command_handler dut (.i_clk(i_clk), .i_srst(i_srst),
		.i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
		.i_wb_sel(sel), .i_wb_dat(wd), .o_wb_ack(ack), .o_wb_dat(rdat),
		.i_own_field_on(fld), .i_passive_mode(pas),
		.o_demodulator_reg(dem), .o_attribute_retry_eff(att),
		.o_raw_retry_forever(forever_q), .o_test_select_reg(tst));
	initial forever #4 i_clk = ~i_clk;
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		logic [31:0] r;
		host.xfer(1'b1, a, d, r);
	endtask
	task automatic rd(input logic [5:0] a, output logic [31:0] r);
		host.xfer(1'b0, a, 32'h0, r);
	endtask
	// item code, n data bytes low first, command, then status
	task automatic cfg(input logic [7:0] it, input logic [87:0] v,
		input int n, input logic [1:0] st);
		logic [31:0] r;
		wr(REG_PAYLOAD, 32'(it));
		for (int i = 0; i < n; i++) wr(REG_PAYLOAD, 32'(v[8*i+:8]));
		wr(REG_CMD, 32'(CMD_RF_SETUP));
		rd(REG_STATUS, r);
		chk(r & 32'h3, 32'(st));
	endtask
	task automatic t_reset;
		chk(32'(dem), 32'h61);
		chk(32'(forever_q), 32'h0);
		rd(REG_RETRY, q);
		chk(q, 32'hFF01FF00);
		rd(6'h3F, q);
		chk(q, 32'h0);
	endtask
	task automatic t_retry;
		cfg(ITEM_RAW_RETRY, 88'hFF, 1, ST_OK);
		chk(32'(forever_q), 32'h1);
		cfg(ITEM_RAW_RETRY, 88'h0102, 2, ST_SYNTAX);
		chk(32'(forever_q), 32'h1);
		cfg(ITEM_RETRIES, 88'h000703, 3, ST_OK);
		rd(REG_RETRY, q);
		chk(q, 32'h000703FF);
		chk(32'(att), 32'h03);
		pas <= 1'b1;
		repeat (3) @(posedge i_clk);
		chk(32'(att), 32'h02);
		pas <= 1'b0;
	endtask
	task automatic t_analog;
		cfg(ITEM_A106, 88'hA1_A2_A3_A4_A5_A6_A7_A8_A9_AA_AB, 11,
			ST_OK);
		rd(REG_A106_BASE, q);
		chk(q, 32'hAB);
		chk(32'(dem), 32'hA5);
		fld <= 1'b1;
		repeat (3) @(posedge i_clk);
		chk(32'(dem), 32'hA7);
		fld <= 1'b0;
		cfg(ITEM_F212, 88'h1122334455667788, 8, ST_OK);
		cfg(ITEM_TYPE_B, 88'h112233, 3, ST_OK);
		cfg(ITEM_CARD_HI, 88'h112233445566778899, 9, ST_OK);
		cfg(ITEM_CARD_HI, 88'h1122, 2, ST_SYNTAX);
		cfg(ITEM_TIMING, 88'h101000, 3, ST_OK);
		cfg(ITEM_TIMING, 88'h051100, 3, ST_SYNTAX);
		foreach (bad[i]) cfg(bad[i], 88'h01, 1, ST_SYNTAX);
	endtask
	task automatic t_test;
		wr(REG_PAYLOAD, 32'h12);
		wr(REG_CMD, 32'(CMD_REG_TEST));
		chk(32'(tst), 32'h0D);
		repeat (60) @(posedge i_clk);
		rd(REG_STATUS, q);
		chk(q & 32'h3, 32'(ST_TESTING));
		// any command other than the test code ends the test, here an empty config
		wr(REG_CMD, 32'(CMD_RF_SETUP));
		chk(32'(tst.prbs_en), 32'h0);
	endtask
	task final_report;
		$display("errors=%0d n_tests=%0d", errors, n_tests);
		if (errors == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge i_clk) begin
		cyc_n <= cyc_n + 1;
		if (cyc_n == 20000) begin
			errors++;
			final_report();
		end
	end
	initial begin
		repeat (3) @(posedge i_clk);
		i_srst <= 1'b0;
		@(posedge i_clk);
		t_reset();
		t_retry();
		t_analog();
		t_test();
		final_report();
	end
endmodule
